// ===== core/ccba_pkg.sv
// ==========================================================
// counter and capture byte access constants
// ==========================================================
package ccba_pkg;

   localparam int CCBA_MODULES = 6;
   localparam int CCBA_BYTE_W = 8;
   localparam int CCBA_WORD_W = 2 * CCBA_BYTE_W;

   typedef logic [CCBA_BYTE_W-1:0] ccba_byte_t;
   typedef logic [CCBA_WORD_W-1:0] ccba_word_t;
   typedef ccba_byte_t ccba_addr_t;

   // ==========================================================
   // register addresses
   // ==========================================================
   localparam ccba_addr_t CCBA_ADDR_COUNTER_LOW = 8'hf9;
   localparam ccba_addr_t CCBA_ADDR_COUNTER_HIGH = 8'hfa;
   localparam ccba_addr_t CCBA_CAP_LOW_ADDR [CCBA_MODULES] =
      '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hce};
   localparam ccba_addr_t CCBA_CAP_HIGH_ADDR [CCBA_MODULES] =
      '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe, 8'hcf};

   // ==========================================================
   // reset values and constants
   // ==========================================================
   localparam ccba_byte_t CCBA_BYTE_RESET = 8'h00;
   localparam ccba_word_t CCBA_WORD_RESET = 16'h0000;
   localparam ccba_word_t CCBA_WORD_ONE = 16'h0001;
   localparam logic CCBA_ENABLE_RESET = 1'b0;

endpackage

// ===== core/ccba_counter_capture.sv
`timescale 1ns/1ps
module ccba_counter_capture
   import ccba_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [CCBA_BYTE_W-1:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [CCBA_BYTE_W-1:0] sfr_wdata,
   output logic [CCBA_BYTE_W-1:0] sfr_rdata,
   input wire logic watchdog_enable_bit,
   input wire logic auto_reload_select,
   input wire logic count_tick,
   input wire logic [CCBA_MODULES-1:0] capture_strobe,
   input wire logic [CCBA_MODULES-1:0] mode_enable_load,
   input wire logic [CCBA_MODULES-1:0] mode_enable_value,
   output logic [CCBA_WORD_W-1:0] main_counter,
   output logic [CCBA_WORD_W-1:0] capture_compare_value [CCBA_MODULES],
   output logic [CCBA_WORD_W-1:0] auto_reload_value [CCBA_MODULES],
   output logic [CCBA_MODULES-1:0] comparator_enable_bit,
   output logic [CCBA_MODULES-1:0] compare_match
);

   // ==========================================================
   // address decode
   // ==========================================================
   function automatic logic [CCBA_MODULES-1:0] addr_match(
      input ccba_addr_t a,
      input ccba_addr_t tbl [CCBA_MODULES]
   );
      logic [CCBA_MODULES-1:0] hit;
      hit = '0;
      for (int i = 0; i < CCBA_MODULES; i++) begin
         hit[i] = (a == tbl[i]);
      end
      return hit;
   endfunction

   logic [CCBA_BYTE_W-1:0] snapshot;
   logic [CCBA_BYTE_W-1:0] next_rdata;
   logic [CCBA_WORD_W-1:0] next_counter;

   wire logic hit_cnt_low = (sfr_addr == CCBA_ADDR_COUNTER_LOW);
   wire logic hit_cnt_high = (sfr_addr == CCBA_ADDR_COUNTER_HIGH);
   wire logic [CCBA_MODULES-1:0] hit_cap_low = addr_match(sfr_addr, CCBA_CAP_LOW_ADDR);
   wire logic [CCBA_MODULES-1:0] hit_cap_high = addr_match(sfr_addr, CCBA_CAP_HIGH_ADDR);

   wire logic wr_cnt_low = sfr_wr && hit_cnt_low && !watchdog_enable_bit;
   wire logic wr_cnt_high = sfr_wr && hit_cnt_high && !watchdog_enable_bit;
   wire logic [CCBA_MODULES-1:0] wr_low = sfr_wr ? hit_cap_low : '0;
   wire logic [CCBA_MODULES-1:0] wr_high = sfr_wr ? hit_cap_high : '0;
   wire logic [CCBA_MODULES-1:0] wr_cap_low = auto_reload_select ? '0 : wr_low;
   wire logic [CCBA_MODULES-1:0] wr_cap_high = auto_reload_select ? '0 : wr_high;
   wire logic [CCBA_MODULES-1:0] wr_rel_low = auto_reload_select ? wr_low : '0;
   wire logic [CCBA_MODULES-1:0] wr_rel_high = auto_reload_select ? wr_high : '0;
   wire logic rd_cnt_low = sfr_rd && hit_cnt_low;

   // ==========================================================
   // main counter
   // ==========================================================
   // byte loads beat the count tick
   always_comb begin
      next_counter = count_tick ? CCBA_WORD_W'(main_counter + CCBA_WORD_ONE) : main_counter;
      if (wr_cnt_low) begin
         next_counter[CCBA_BYTE_W-1:0] = sfr_wdata;
      end
      if (wr_cnt_high) begin
         next_counter[CCBA_WORD_W-1:CCBA_BYTE_W] = sfr_wdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         main_counter <= CCBA_WORD_RESET;
      end else begin
         main_counter <= next_counter;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         snapshot <= CCBA_BYTE_RESET;
      end else if (rd_cnt_low) begin
         snapshot <= main_counter[CCBA_WORD_W-1:CCBA_BYTE_W];
      end
   end

   // ==========================================================
   // capture, reload and comparator per module
   // ==========================================================
   for (genvar m = 0; m < CCBA_MODULES; m++) begin : g_mod
      always_ff @(posedge clk_sys) begin
         if (reset) begin
            capture_compare_value[m][CCBA_BYTE_W-1:0] <= CCBA_BYTE_RESET;
         end else if (wr_cap_low[m]) begin
            capture_compare_value[m][CCBA_BYTE_W-1:0] <= sfr_wdata;
         end else if (capture_strobe[m]) begin
            capture_compare_value[m][CCBA_BYTE_W-1:0] <= main_counter[CCBA_BYTE_W-1:0];
         end
      end

      always_ff @(posedge clk_sys) begin
         if (reset) begin
            capture_compare_value[m][CCBA_WORD_W-1:CCBA_BYTE_W] <= CCBA_BYTE_RESET;
         end else if (wr_cap_high[m]) begin
            capture_compare_value[m][CCBA_WORD_W-1:CCBA_BYTE_W] <= sfr_wdata;
         end else if (capture_strobe[m]) begin
            capture_compare_value[m][CCBA_WORD_W-1:CCBA_BYTE_W] <=
               main_counter[CCBA_WORD_W-1:CCBA_BYTE_W];
         end
      end

      always_ff @(posedge clk_sys) begin
         if (reset) begin
            auto_reload_value[m] <= CCBA_WORD_RESET;
         end else if (wr_rel_low[m]) begin
            auto_reload_value[m][CCBA_BYTE_W-1:0] <= sfr_wdata;
         end else if (wr_rel_high[m]) begin
            auto_reload_value[m][CCBA_WORD_W-1:CCBA_BYTE_W] <= sfr_wdata;
         end
      end

      // low write clears, high write sets
      always_ff @(posedge clk_sys) begin
         if (reset) begin
            comparator_enable_bit[m] <= CCBA_ENABLE_RESET;
         end else if (wr_high[m]) begin
            comparator_enable_bit[m] <= 1'b1;
         end else if (wr_low[m]) begin
            comparator_enable_bit[m] <= 1'b0;
         end else if (mode_enable_load[m]) begin
            comparator_enable_bit[m] <= mode_enable_value[m];
         end
      end

      always_ff @(posedge clk_sys) begin
         if (reset) begin
            compare_match[m] <= 1'b0;
         end else begin
            compare_match[m] <= comparator_enable_bit[m] &&
               (main_counter == capture_compare_value[m]);
         end
      end
   end

   // ==========================================================
   // read path
   // ==========================================================
   always_comb begin
      next_rdata = CCBA_BYTE_RESET;
      if (hit_cnt_low) begin
         next_rdata = main_counter[CCBA_BYTE_W-1:0];
      end
      if (hit_cnt_high) begin
         next_rdata = snapshot;
      end
      for (int i = 0; i < CCBA_MODULES; i++) begin
         if (hit_cap_low[i]) begin
            next_rdata = auto_reload_select ? auto_reload_value[i][CCBA_BYTE_W-1:0] :
               capture_compare_value[i][CCBA_BYTE_W-1:0];
         end
         if (hit_cap_high[i]) begin
            next_rdata = auto_reload_select ?
               auto_reload_value[i][CCBA_WORD_W-1:CCBA_BYTE_W] :
               capture_compare_value[i][CCBA_WORD_W-1:CCBA_BYTE_W];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sfr_rdata <= CCBA_BYTE_RESET;
      end else if (sfr_rd) begin
         sfr_rdata <= next_rdata;
      end
   end

   // ==========================================================
   // assertions
   // ==========================================================
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   cnt_low_load_a: assert property (
      wr_cnt_low |=> main_counter[CCBA_BYTE_W-1:0] == $past(sfr_wdata))
      else $error("counter low byte not loaded");

   low_lock_a: assert property (
      sfr_wr && hit_cnt_low && watchdog_enable_bit && !count_tick |=> $stable(main_counter))
      else $error("counter low changed under watchdog");

   cnt_high_load_a: assert property (
      wr_cnt_high |=> main_counter[CCBA_WORD_W-1:CCBA_BYTE_W] == $past(sfr_wdata))
      else $error("counter high byte not loaded");

   snapshot_read_a: assert property (
      rd_cnt_low ##1 (sfr_rd && hit_cnt_high && !rd_cnt_low)
      |=> sfr_rdata == $past(main_counter[CCBA_WORD_W-1:CCBA_BYTE_W], 2))
      else $error("high read not from snapshot");

   high_lock_a: assert property (
      sfr_wr && hit_cnt_high && watchdog_enable_bit && !count_tick |=> $stable(main_counter))
      else $error("counter high changed under watchdog");

   cap_low_wr_a: assert property (
      wr_cap_low[0] |=> capture_compare_value[0][CCBA_BYTE_W-1:0] == $past(sfr_wdata))
      else $error("capture low byte not written");

   cap_high_wr_a: assert property (
      wr_cap_high[5] |=> capture_compare_value[5][CCBA_WORD_W-1:CCBA_BYTE_W] == $past(sfr_wdata))
      else $error("capture high byte not written");

   reload_alias_a: assert property (
      wr_rel_low[1] |=> auto_reload_value[1][CCBA_BYTE_W-1:0] == $past(sfr_wdata)
         && $stable(capture_compare_value[1]))
      else $error("reload alias write wrong");

   select_read_a: assert property (
      sfr_rd && hit_cap_high[2] && auto_reload_select
      |=> sfr_rdata == $past(auto_reload_value[2][CCBA_WORD_W-1:CCBA_BYTE_W]))
      else $error("reload select read wrong");

   enable_clear_a: assert property (
      sfr_wr && hit_cap_low[3] |=> !comparator_enable_bit[3])
      else $error("low write did not clear enable");

   enable_set_a: assert property (
      sfr_wr && hit_cap_high[4] |=> comparator_enable_bit[4] [*1])
      else $error("high write did not set enable");

   compare_gate_a: assert property (
      !comparator_enable_bit[0] |=> !compare_match[0])
      else $error("match without enable");

   count_run_a: assert property (
      count_tick && !sfr_wr |=> main_counter == $past(main_counter) + CCBA_WORD_ONE)
      else $error("counter did not advance");

   low_read_a: assert property (
      sfr_rd && hit_cnt_low |=> sfr_rdata == $past(main_counter[CCBA_BYTE_W-1:0]))
      else $error("counter low read wrong");

   snapshot_load_a: assert property (
      rd_cnt_low |=> snapshot == $past(main_counter[CCBA_WORD_W-1:CCBA_BYTE_W]))
      else $error("snapshot not loaded on low read");

   unmapped_read_a: assert property (
      sfr_rd && !(hit_cnt_low || hit_cnt_high || (|hit_cap_low) || (|hit_cap_high))
      |=> sfr_rdata == CCBA_BYTE_RESET)
      else $error("unmapped read not zero");

   capture_hold_a: assert property (
      !sfr_wr && !capture_strobe[5] |=> $stable(capture_compare_value[5]))
      else $error("capture value changed without cause");

   reload_high_a: assert property (
      wr_rel_high[4] |=> auto_reload_value[4][CCBA_WORD_W-1:CCBA_BYTE_W] == $past(sfr_wdata))
      else $error("reload high byte not written");

   cap_high_rd_a: assert property (
      sfr_rd && hit_cap_high[0] && !auto_reload_select
      |=> sfr_rdata == $past(capture_compare_value[0][CCBA_WORD_W-1:CCBA_BYTE_W]))
      else $error("capture select read wrong");

   mode_load_a: assert property (
      mode_enable_load[2] && !sfr_wr
      |=> comparator_enable_bit[2] == $past(mode_enable_value[2]))
      else $error("mode enable load lost");

   match_on_a: assert property (
      comparator_enable_bit[3] && main_counter == capture_compare_value[3]
      |=> compare_match[3])
      else $error("enabled match missed");

   // ==========================================================
   // cover properties
   // ==========================================================
   cover_strobe_c: cover property (|capture_strobe);
   cover_snapshot_c: cover property (rd_cnt_low ##1 sfr_rd && hit_cnt_high);
   cover_lock_c: cover property (sfr_wr && hit_cnt_low && watchdog_enable_bit);
   cover_match_c: cover property (compare_match[0]);
   cover_reload_c: cover property (|wr_rel_high);

endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import ccba_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic watchdog_enable_bit = 1'b0;
   logic auto_reload_select = 1'b0;
   logic count_tick = 1'b0;
   ccba_addr_t sfr_addr = 8'h00;
   ccba_byte_t sfr_wdata = 8'h00;
   ccba_byte_t sfr_rdata;
   logic [CCBA_MODULES-1:0] capture_strobe = '0;
   logic [CCBA_MODULES-1:0] mode_enable_load = '0;
   logic [CCBA_MODULES-1:0] mode_enable_value = '0;
   logic [CCBA_MODULES-1:0] comparator_enable_bit;
   logic [CCBA_MODULES-1:0] compare_match;
   ccba_word_t main_counter;
   ccba_word_t cap_v [CCBA_MODULES];
   ccba_word_t ar_v [CCBA_MODULES];
   ccba_word_t exp_cap [CCBA_MODULES];
   ccba_word_t exp_ar [CCBA_MODULES];
   ccba_word_t v;
   logic [15:0] lfsr = 16'h4330;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;

   always #10 clk_sys = ~clk_sys;

   ccba_counter_capture i_ccba_counter_capture (
      .clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .watchdog_enable_bit(watchdog_enable_bit), .auto_reload_select(auto_reload_select),
      .count_tick(count_tick), .capture_strobe(capture_strobe),
      .mode_enable_load(mode_enable_load), .mode_enable_value(mode_enable_value),
      .main_counter(main_counter), .capture_compare_value(cap_v),
      .auto_reload_value(ar_v), .comparator_enable_bit(comparator_enable_bit),
      .compare_match(compare_match)
   );

   // ==========================================================
   // helpers
   // ==========================================================
   function logic [15:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction

   // expected match vector once every enable is set
   function logic [CCBA_MODULES-1:0] match_vec(input ccba_word_t c);
      for (int m = 0; m < CCBA_MODULES; m++) begin
         match_vec[m] = (exp_cap[m] === c);
      end
   endfunction

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task wr(input ccba_addr_t a, input ccba_byte_t d);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
   endtask

   task rd_chk(input ccba_addr_t a, input ccba_byte_t e);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      chk($sformatf("rdata at %h", a), {8'h00, e}, {8'h00, sfr_rdata});
   endtask

   // counter low then high in back-to-back cycles
   task rd_pair(input ccba_byte_t el, input ccba_byte_t eh);
      @(negedge clk_sys);
      sfr_addr = CCBA_ADDR_COUNTER_LOW;
      sfr_rd = 1'b1;
      @(negedge clk_sys);
      chk("pair low", {8'h00, el}, {8'h00, sfr_rdata});
      sfr_addr = CCBA_ADDR_COUNTER_HIGH;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
      chk("pair high", {8'h00, eh}, {8'h00, sfr_rdata});
   endtask

   task tick(input int n);
      repeat (n) begin
         @(negedge clk_sys);
         count_tick = 1'b1;
      end
      @(negedge clk_sys);
      count_tick = 1'b0;
   endtask

   task end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         end_of_test();
      end
   end

   // ==========================================================
   // main sequence
   // ==========================================================
   initial begin
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      rd_chk(CCBA_ADDR_COUNTER_LOW, 8'h00);
      rd_chk(CCBA_ADDR_COUNTER_HIGH, 8'h00);
      for (int m = 0; m < CCBA_MODULES; m++) begin
         rd_chk(CCBA_CAP_LOW_ADDR[m], 8'h00);
         rd_chk(CCBA_CAP_HIGH_ADDR[m], 8'h00);
      end
      rd_chk(8'hf8, 8'h00);
      chk("enables", 16'h0000, {10'h000, comparator_enable_bit});
      $display("test reset done");
      v = rnd();
      wr(CCBA_ADDR_COUNTER_LOW, v[7:0]);
      wr(CCBA_ADDR_COUNTER_HIGH, v[15:8]);
      chk("main_counter", v, main_counter);
      rd_chk(CCBA_ADDR_COUNTER_LOW, v[7:0]);
      rd_chk(CCBA_ADDR_COUNTER_HIGH, v[15:8]);
      $display("test counter access done");
      watchdog_enable_bit = 1'b1;
      wr(CCBA_ADDR_COUNTER_LOW, ~v[7:0]);
      wr(CCBA_ADDR_COUNTER_HIGH, ~v[15:8]);
      chk("locked counter", v, main_counter);
      watchdog_enable_bit = 1'b0;
      $display("test watchdog lock done");
      // low byte about to carry into the high byte
      wr(CCBA_ADDR_COUNTER_LOW, 8'hfe);
      wr(CCBA_ADDR_COUNTER_HIGH, 8'h00);
      rd_chk(CCBA_ADDR_COUNTER_LOW, 8'hfe);
      tick(4);
      chk("main_counter", 16'h0102, main_counter);
      rd_chk(CCBA_ADDR_COUNTER_HIGH, 8'h00);
      rd_chk(CCBA_ADDR_COUNTER_LOW, 8'h02);
      rd_chk(CCBA_ADDR_COUNTER_HIGH, 8'h01);
      // counter keeps running while the pair is read
      wr(CCBA_ADDR_COUNTER_LOW, 8'hfe);
      count_tick = 1'b1;
      rd_pair(8'hff, 8'h01);
      count_tick = 1'b0;
      chk("main_counter", 16'h0201, main_counter);
      $display("test snapshot done");
      for (int m = 0; m < CCBA_MODULES; m++) begin
         for (int s = 0; s < 2; s++) begin
            auto_reload_select = s[0];
            v = rnd();
            wr(CCBA_CAP_HIGH_ADDR[m], v[15:8]);
            chk("enable set", 16'h0001, {15'h0000, comparator_enable_bit[m]});
            wr(CCBA_CAP_LOW_ADDR[m], v[7:0]);
            chk("enable clear", 16'h0000, {15'h0000, comparator_enable_bit[m]});
            wr(CCBA_CAP_HIGH_ADDR[m], v[15:8]);
            chk("enable set", 16'h0001, {15'h0000, comparator_enable_bit[m]});
            if (s == 1) begin
               exp_ar[m] = v;
            end else begin
               exp_cap[m] = v;
            end
            rd_chk(CCBA_CAP_LOW_ADDR[m], v[7:0]);
            rd_chk(CCBA_CAP_HIGH_ADDR[m], v[15:8]);
         end
      end
      auto_reload_select = 1'b0;
      for (int m = 0; m < CCBA_MODULES; m++) begin
         chk($sformatf("capture value %0d", m), exp_cap[m], cap_v[m]);
         chk($sformatf("auto reload %0d", m), exp_ar[m], ar_v[m]);
         rd_chk(CCBA_CAP_LOW_ADDR[m], exp_cap[m][7:0]);
      end
      $display("test capture access done");
      v = exp_cap[2];
      wr(CCBA_ADDR_COUNTER_LOW, v[7:0]);
      wr(CCBA_ADDR_COUNTER_HIGH, v[15:8]);
      @(negedge clk_sys);
      chk("compare_match", {10'h000, match_vec(v)}, {10'h000, compare_match});
      // module 2 disabled by mode load, module 3 captures the counter
      mode_enable_load = 6'h04;
      @(negedge clk_sys);
      mode_enable_load = '0;
      capture_strobe = 6'h08;
      @(negedge clk_sys);
      capture_strobe = '0;
      exp_cap[3] = v;
      chk("captured value", v, cap_v[3]);
      chk("mode load", 16'h0000, {15'h0000, comparator_enable_bit[2]});
      @(negedge clk_sys);
      chk("gated match", {10'h000, match_vec(v) & 6'h3b}, {10'h000, compare_match});
      $display("test compare done");
      end_of_test();
   end
endmodule
